/* File: src/mig_pkg.sv */
// Package for the interrupt mask gate: offsets, layouts, reset values
package mig_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] MIG_ADDR_IRQ_ENABLE_MASK = 8'h06;
	localparam int MIG_REG_WIDTH = 16;
	localparam logic [15:0] MIG_IRQ_ENABLE_MASK_RESET = 16'h0000;
	// Bits 7 to 4 are reserved: not stored, read as zero
	localparam logic [15:0] MIG_IRQ_ENABLE_MASK_WRITABLE = 16'hff0f;
	localparam logic [15:0] MIG_RD_UNMAPPED = 16'h0000;

	// ==========================================================
	// Field layouts, most significant field first
	typedef struct packed {
		logic dsp_overrun_irq_enable;
		logic dsp_done_irq_enable;
		logic reactive_dir_irq_enable;
		logic real_dir_irq_enable;
		logic missing_zero_cross_irq_enable;
		logic low_voltage_irq_enable;
		logic high_voltage_irq_enable;
		logic high_current_irq_enable;
		logic [3:0] reserved;
		logic current_vector_sum_irq_enable;
		logic accum_wrap_irq_enable;
		logic checksum_change_irq_enable;
		logic power_fail_irq_enable;
	} mig_mask_s;

	typedef struct packed {
		logic dsp_overrun_flag;
		logic dsp_cycle_done_flag;
		logic reactive_dir_change_flag;
		logic real_dir_change_flag;
		logic missing_zero_cross_flag;
		logic low_voltage_flag;
		logic high_voltage_flag;
		logic high_current_flag;
		logic [3:0] reserved;
		logic current_vector_sum_flag;
		logic accum_wrap_flag;
		logic config_checksum_change_flag;
		logic power_fail_warning_flag;
	} mig_flag_s;

endpackage : mig_pkg

/* File: src/mig_irq_mask_gate.sv */
// Interrupt enable mask register and active-low interrupt request gate
//
// Summary of operation
// - Overrun flag with mask bit 15 set drives the request pin active.
// - Cycle-done flag with mask bit 14 set drives the request active.
// - Reactive direction flag with mask bit 13 set drives the request.
// - Real direction flag with mask bit 12 set drives the request.
// - Missing zero-cross flag with mask bit 11 set drives the request.
// - Low-voltage flag with mask bit 10 set drives the request active.
// - High-voltage flag with mask bit 9 set drives the request active.
// - High-current flag with mask bit 8 set drives the request active.
// - Vector-sum flag with mask bit 3 set drives the request active.
// - Accumulator wrap flag with mask bit 2 set drives the request.
// - Checksum change flag with mask bit 1 set drives the request.
// - Power-fail flag with mask bit 0 set drives the request active.
// - Mask bit n gates only the flag at the same bit position n.
`timescale 1ns/10ps
module mig_irq_mask_gate
	import mig_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire mig_flag_s flagsIn,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [15:0] regRdData,
	output logic regRdValid,
	output mig_mask_s irqEnable,
	output logic irqN
);

	// ==========================================================
	// Address decode
	logic maskWrHit;
	logic maskRdHit;
	logic [15:0] pending;
	logic anyPending;

	always_comb
	begin
		maskWrHit = 1'b0;
		maskRdHit = 1'b0;
		if (regAddr == MIG_ADDR_IRQ_ENABLE_MASK)
		begin
			maskWrHit = regWrEn;
			maskRdHit = regRdEn;
		end
	end

	// ==========================================================
	// Mask register
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irqEnable <= mig_mask_s'(MIG_IRQ_ENABLE_MASK_RESET);
		else if (maskWrHit)
			// Reserved bits never store, so they cannot gate anything
			irqEnable <= mig_mask_s'(regWrData &
				MIG_IRQ_ENABLE_MASK_WRITABLE);
	end

	// ==========================================================
	// Read port: one cycle latency, unmapped reads return zero
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regRdData <= MIG_RD_UNMAPPED;
			regRdValid <= 1'b0;
		end
		else
		begin
			regRdValid <= regRdEn;
			if (maskRdHit)
				regRdData <= 16'(irqEnable);
			else
				regRdData <= MIG_RD_UNMAPPED;
		end
	end

	// ==========================================================
	// Per-bit gating, flag n against enable n
	genvar gi;
	generate
		for (gi = 0; gi < MIG_REG_WIDTH; gi++)
		begin : gBit
			assign pending[gi] = flagsIn[gi] &
				irqEnable[gi] &
				MIG_IRQ_ENABLE_MASK_WRITABLE[gi];
		end
	endgenerate

	assign anyPending = |pending;

	// Level driven: the pin follows the enabled flags one edge later, so it releases
	// once no set flag is enabled, by a flag clear or by a mask write
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irqN <= 1'b1;
		else
			irqN <= ~anyPending;
	end

	// ==========================================================
	// Assertions
	logic firstCycle;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			firstCycle <= 1'b1;
		else
			firstCycle <= 1'b0;
	end

	AST_OVERRUN: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.dsp_overrun_flag && irqEnable.dsp_overrun_irq_enable
		|=> !irqN)
		else $error("overrun enabled but request not active");

	AST_DONE: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.dsp_cycle_done_flag && irqEnable.dsp_done_irq_enable
		|=> !irqN)
		else $error("cycle done enabled but request not active");

	AST_REACTIVE: assert property (@(posedge clock)
		disable iff (!rst_n)
		flagsIn.reactive_dir_change_flag &&
		irqEnable.reactive_dir_irq_enable |=> !irqN)
		else $error("reactive direction enabled but request not active");

	AST_REAL: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.real_dir_change_flag && irqEnable.real_dir_irq_enable
		|=> !irqN)
		else $error("real direction enabled but request not active");

	AST_NOZERO: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.missing_zero_cross_flag &&
		irqEnable.missing_zero_cross_irq_enable |=> !irqN)
		else $error("zero cross enabled but request not active");

	AST_LOWV: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.low_voltage_flag && irqEnable.low_voltage_irq_enable
		|=> !irqN)
		else $error("low voltage enabled but request not active");

	AST_HIGHV: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.high_voltage_flag && irqEnable.high_voltage_irq_enable
		|=> !irqN)
		else $error("high voltage enabled but request not active");

	AST_HIGHI: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.high_current_flag && irqEnable.high_current_irq_enable
		|=> !irqN)
		else $error("high current enabled but request not active");

	AST_VSUM: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.current_vector_sum_flag &&
		irqEnable.current_vector_sum_irq_enable |=> !irqN)
		else $error("vector sum enabled but request not active");

	AST_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.accum_wrap_flag && irqEnable.accum_wrap_irq_enable
		|=> !irqN)
		else $error("accumulator wrap enabled but request not active");

	AST_CHKSUM: assert property (@(posedge clock) disable iff (!rst_n)
		flagsIn.config_checksum_change_flag &&
		irqEnable.checksum_change_irq_enable |=> !irqN)
		else $error("checksum change enabled but request not active");

	AST_POWER_FAIL: assert property (@(posedge clock)
		disable iff (!rst_n)
		flagsIn.power_fail_warning_flag && irqEnable.power_fail_irq_enable
		|=> !irqN)
		else $error("power fail enabled but request not active");

	AST_GATED_QUIET: assert property (@(posedge clock)
		disable iff (!rst_n)
		((16'(flagsIn) & 16'(irqEnable)) == 16'h0000) |=> irqN)
		else $error("request active with no enabled flag");

	AST_HOLD_WHILE_SET: assert property (@(posedge clock)
		disable iff (!rst_n)
		anyPending ##1 anyPending |=> !irqN [*1])
		else $error("request released while enabled flag still set");

	AST_RESERVED_ZERO: assert property (@(posedge clock)
		disable iff (!rst_n)
		irqEnable.reserved == 4'h0)
		else $error("reserved mask bits not zero");

	AST_RESET_CLEAR: assert property (@(posedge clock)
		disable iff (!rst_n)
		firstCycle |-> 16'(irqEnable) == MIG_IRQ_ENABLE_MASK_RESET)
		else $error("mask not cleared after reset");

	AST_WRITE_TAKES: assert property (@(posedge clock)
		disable iff (!rst_n)
		maskWrHit |=> 16'(irqEnable) ==
			($past(regWrData) & MIG_IRQ_ENABLE_MASK_WRITABLE))
		else $error("mask write not stored");

	AST_READ_BACK: assert property (@(posedge clock)
		disable iff (!rst_n)
		maskRdHit && !maskWrHit |=> regRdValid &&
			regRdData == 16'(irqEnable))
		else $error("mask read back wrong");

	COV_ENABLE_FIRE: cover property (@(posedge clock) disable iff (!rst_n)
		maskWrHit ##1 anyPending ##1 !irqN);

	COV_MASKED_FLAG: cover property (@(posedge clock) disable iff (!rst_n)
		(16'(flagsIn) != 16'h0000) && !anyPending ##1 irqN);

	COV_SERVICE: cover property (@(posedge clock) disable iff (!rst_n)
		!irqN ##1 !anyPending ##1 irqN);

endmodule : mig_irq_mask_gate

/* File: sim/mig_host_model.sv */
// Host-side model of the event flag register feeding the mask gate
`timescale 1ns/10ps
module mig_host_model
	import mig_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] setMask,
	input wire logic [15:0] clrMask,
	output mig_flag_s flags
);
	// ==========================================================
	// Flag storage
	// Clear wins over set, so a serviced event never lingers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			flags <= mig_flag_s'(16'h0000);
		else
			flags <= mig_flag_s'((flags | setMask) & ~clrMask);
	end
endmodule : mig_host_model

/* File: sim/mig_irq_mask_gate_tb_top.sv */
// Self-checking testbench for the interrupt mask gate
`timescale 1ns/10ps
module mig_irq_mask_gate_tb_top
	import mig_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [15:0] setMask = 16'h0000;
	logic [15:0] clrMask = 16'h0000;
	logic [15:0] regRdData;
	logic regRdValid;
	mig_flag_s flags;
	mig_mask_s irqEnable;
	logic irqN;
	int n_mismatch = 0;
	int checks = 0;

	mig_host_model host (.clock(clock), .rst_n(rst_n), .setMask(setMask),
		.clrMask(clrMask), .flags(flags));
	mig_irq_mask_gate uut (.clock(clock), .rst_n(rst_n), .flagsIn(flags),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
		.irqEnable(irqEnable), .irqN(irqN));

	// ==========================================================
	// Clock and helpers
	initial
	begin
		forever #20 clock = ~clock;
	end

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Write is taken at the second edge; irqEnable settles right after
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clock);
		regWrEn <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clock);
		regRdEn <= 1'b0;
		#1;
		chk("regRdValid", {15'h0000, regRdValid}, 16'h0001);
		chk("regRdData", regRdData, exp);
	endtask : rd

	// Host pulse takes one edge, the registered request one more
	task automatic flagOp(input logic [15:0] s, input logic [15:0] c);
		@(posedge clock);
		setMask <= s;
		clrMask <= c;
		@(posedge clock);
		setMask <= 16'h0000;
		clrMask <= 16'h0000;
		@(posedge clock);
		#1;
	endtask : flagOp

	// ==========================================================
	// Scenarios
	task automatic testReset();
		chk("irqEnable", irqEnable, 16'h0000);
		chk("irqN", {15'h0000, irqN}, 16'h0001);
		flagOp(16'hffff, 16'h0000);
		chk("irqN", {15'h0000, irqN}, 16'h0001);
		flagOp(16'h0000, 16'hffff);
		$display("test reset done");
	endtask : testReset

	// One mask bit at a time, with the neighbouring flag set as decoy
	task automatic testPerBit();
		logic [15:0] bitN;
		logic [15:0] decoy;
		for (int n = 0; n < 16; n++)
		begin
			bitN = 16'h0001 << n;
			decoy = (n == 15) ? 16'h0001 : (bitN << 1);
			wr(MIG_ADDR_IRQ_ENABLE_MASK, bitN);
			chk("irqEnable", irqEnable, bitN & 16'hff0f);
			flagOp(decoy, 16'h0000);
			chk("irqN", {15'h0000, irqN}, 16'h0001);
			flagOp(bitN, 16'h0000);
			chk("irqN", {15'h0000, irqN},
				{15'h0000,
				~|(bitN & 16'hff0f)});
			flagOp(16'h0000, bitN);
			chk("irqN", {15'h0000, irqN}, 16'h0001);
			flagOp(16'h0000, decoy);
		end
		$display("test per-bit done");
	endtask : testPerBit

	task automatic testRegs();
		wr(MIG_ADDR_IRQ_ENABLE_MASK, 16'hffff);
		wr(8'h07, 16'h0000);
		chk("irqEnable", irqEnable, 16'hff0f);
		rd(8'h07, 16'h0000);
		rd(MIG_ADDR_IRQ_ENABLE_MASK, 16'hff0f);
		flagOp(16'h8000, 16'h0000);
		chk("irqN", {15'h0000, irqN}, 16'h0000);
		wr(MIG_ADDR_IRQ_ENABLE_MASK, 16'h7fff);
		#40;
		chk("irqN", {15'h0000, irqN}, 16'h0001);
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk("irqEnable", irqEnable, 16'h0000);
		chk("irqN", {15'h0000, irqN}, 16'h0001);
		$display("test registers done");
	endtask : testRegs

	// Two enabled flags: the request holds until the host clears both
	task automatic testService();
		wr(MIG_ADDR_IRQ_ENABLE_MASK, 16'h8001);
		flagOp(16'h8001, 16'h0000);
		chk("irqN", {15'h0000, irqN}, 16'h0000);
		repeat (4) @(posedge clock);
		#1;
		chk("irqN", {15'h0000, irqN}, 16'h0000);
		flagOp(16'h0000, 16'h8000);
		chk("irqN", {15'h0000, irqN}, 16'h0000);
		flagOp(16'h0000, 16'h0001);
		chk("irqN", {15'h0000, irqN}, 16'h0001);
		// Read in the write cycle returns the mask from before the write
		@(posedge clock);
		regAddr <= MIG_ADDR_IRQ_ENABLE_MASK;
		regWrData <= 16'h00f2;
		regWrEn <= 1'b1;
		regRdEn <= 1'b1;
		@(posedge clock);
		regWrEn <= 1'b0;
		regRdEn <= 1'b0;
		#1;
		chk("regRdValid", {15'h0000, regRdValid}, 16'h0001);
		chk("regRdData", regRdData, 16'h8001);
		chk("irqEnable", irqEnable, 16'h0002);
		@(posedge clock);
		#1;
		chk("regRdValid", {15'h0000, regRdValid}, 16'h0000);
		chk("regRdData", regRdData, 16'h0000);
		$display("test service done");
	endtask : testService

	// ==========================================================
	// Verdict and main sequence
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	initial
	begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		testReset();
		testPerBit();
		testService();
		testRegs();
		stop_test();
	end
endmodule : mig_irq_mask_gate_tb_top
